// >>> rtl/fsl_spin_step_limiter.sv
// Fan spin-up sequencer, drive step limiter, minimum floor and stall detector.
// Assumes tach, target and PID request inputs are synchronous to i_ref_clk.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// R1 - Spin level code 0..7 selects 30% to 65% drive in 5% steps.
// R2 - Spin time code 0..3 selects 250 ms, 500 ms, 1 s, 2 s.
// R3 - No valid tach before spin time ends raises an interrupt.
// R4 - With closed loop active, a failed spin-up restarts immediately.
// R5 - Derivative option 00 or 01 clips each update change to the step.
// R6 - Derivative option 10 or 11 applies no step limit.
// R7 - Base selection 1 to 3: step applies to 10-bit duty, 25% maximum.
// R8 - Base selection 0: 8-bit duty, step applies directly, 100% maximum.
// R9 - Closed loop never drives below minimum drive unless target is FFh; here the floor is applied only to run-state updates, not to the spin level.
// R10 - In closed loop, a stopped fan is always restarted.
// R11 - Software writes minimum drive before tach target; rewrites target after raising it.
// R12 - At spin-up end the tach reading is checked against the threshold.
// R13 - Tach reading above threshold is a stall; closed loop then spins up.
// R14 - Without closed loop, spin-up starts only when direct drive leaves 00h.
// R15 - Tach target above threshold is ignored; the present drive is held.
// R16 - Unless kick is skipped, drive 100% for a quarter of spin time.
// R17 - Target high byte FFh turns drive off; leaving FFh starts spin-up.
// R18 - Tach reading counts slow-clock periods per revolution; larger means slower.
// R19 - Spin-up failure sets a sticky status flag cleared by software.
module fsl_spin_step_limiter #(
	parameter int P_SPIN_BASE_CYCLES = fsl_pkg::SPIN_BASE_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_closed_loop_speed_control,
	input wire logic [1:0] i_derivative_option,
	input wire logic [1:0] i_pwm_base,
	input wire logic i_update_tick,
	input wire logic [9:0] i_drive_request,
	input wire logic [7:0] i_direct_drive,
	input wire logic [12:0] i_tach_reading,
	input wire logic i_tach_valid,
	input wire logic [12:0] i_tach_target,
	output logic [9:0] o_drive,
	output logic o_spin_active,
	output logic o_irq
);

	fsl_pkg::fsl_state_e state;
	fsl_pkg::fsl_state_e next_state;
	logic [7:0] spin_up_config;
	logic [7:0] drive_step_limit;
	logic [7:0] minimum_drive;
	logic [7:0] stall_count_threshold;
	logic [fsl_pkg::STAT_W-1:0] status;
	logic [fsl_pkg::STAT_W-1:0] mask;
	logic [fsl_pkg::STAT_W-1:0] stat_set;
	logic [fsl_pkg::STAT_W-1:0] stat_clr;
	logic [31:0] elapsed;
	logic tach_seen;
	logic [9:0] next_drive;

	logic bus_req;
	logic bus_wr;
	logic [5:0] bus_idx;
	logic closed_loop_speed_control;
	logic eight_bit;
	logic [9:0] full;
	logic [9:0] min_ext;
	logic [9:0] direct_ext;
	logic [2:0] spin_drive_level;
	logic [1:0] spin_duration_select;
	logic skip_full_kick;
	logic [6:0] spin_pct;
	logic [16:0] lvl_prod;
	logic [9:0] spin_level;
	logic [31:0] spin_total;
	logic [31:0] kick_len;
	logic [7:0] tach_hi;
	logic [7:0] target_hi;
	logic stall;
	logic target_ff;
	logic target_bad;
	logic spinning;
	logic spin_end;
	logic spin_ok;
	logic retry;
	logic stall_restart;
	logic start_auto;
	logic start_manual;
	logic start_spin;
	logic signed [11:0] diff;
	logic signed [11:0] step_s;
	logic [10:0] cand;
	logic [9:0] run_drive;

	assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign bus_wr = bus_req && i_wb_we && i_wb_sel[0];
	assign bus_idx = i_wb_adr[fsl_pkg::ADR_IDX_MSB:fsl_pkg::ADR_IDX_LSB];

	// In 8-bit mode the duty sits in the low byte; 10-bit mode scales bytes up.
	assign closed_loop_speed_control = i_closed_loop_speed_control;
	assign eight_bit = (i_pwm_base == fsl_pkg::BASE_8BIT); // R8
	assign full = eight_bit ? fsl_pkg::FULL_8 : fsl_pkg::FULL_10; // R7
	assign min_ext = eight_bit ? {2'h0, minimum_drive} : {minimum_drive, 2'h0};
	assign direct_ext = eight_bit ? {2'h0, i_direct_drive} : {i_direct_drive, 2'h0};

	assign spin_drive_level = spin_up_config[fsl_pkg::SPIN_DRIVE_LEVEL_MSB:fsl_pkg::SPIN_DRIVE_LEVEL_LSB];
	assign spin_duration_select =
		spin_up_config[fsl_pkg::SPIN_TIME_MSB:fsl_pkg::SPIN_TIME_LSB];
	assign skip_full_kick = spin_up_config[fsl_pkg::SKIP_KICK_BIT];

	assign spin_pct = 7'(fsl_pkg::PCT_BASE + fsl_pkg::PCT_STEP * {4'h0, spin_drive_level}); // R1
	assign lvl_prod = {10'h000, spin_pct} * {7'h00, full};
	assign spin_level = 10'(lvl_prod / fsl_pkg::PCT_FULL); // R1

	assign spin_total = 32'(P_SPIN_BASE_CYCLES) << spin_duration_select; // R2
	assign kick_len = spin_total >> 2; // R16

	// The comparisons use the reading's high byte, as the threshold is one byte.
	assign tach_hi = i_tach_reading[fsl_pkg::TACH_HI_MSB:fsl_pkg::TACH_HI_LSB]; // R18
	assign target_hi = i_tach_target[fsl_pkg::TACH_HI_MSB:fsl_pkg::TACH_HI_LSB];
	assign stall = tach_hi > stall_count_threshold; // R13
	assign target_ff = target_hi == fsl_pkg::TARGET_OFF;
	assign target_bad = target_hi > stall_count_threshold; // R15

	assign spinning = (state == fsl_pkg::ST_KICK) || (state == fsl_pkg::ST_SPIN);
	assign spin_end = spinning && (elapsed == spin_total - 32'h00000001); // R2
	assign spin_ok = (tach_seen || i_tach_valid) && !stall; // R3 R12
	assign retry = spin_end && !spin_ok && closed_loop_speed_control; // R4
	assign stall_restart = state == fsl_pkg::ST_RUN && i_tach_valid && stall; // R10 R13
	assign start_auto = closed_loop_speed_control && !target_ff && (state == fsl_pkg::ST_OFF || stall_restart); // R17
	assign start_manual = !closed_loop_speed_control && state == fsl_pkg::ST_OFF && i_direct_drive != 8'h00; // R14
	assign start_spin = start_auto || start_manual || retry;

	always_comb
	begin
		next_state = state;
		if (closed_loop_speed_control && target_ff)
			next_state = fsl_pkg::ST_OFF; // R17
		else if (start_spin)
			next_state = skip_full_kick ? fsl_pkg::ST_SPIN : fsl_pkg::ST_KICK; // R4 R16
		else
		begin
			case (state)
				fsl_pkg::ST_KICK:
					if (elapsed == kick_len - 32'h00000001)
						next_state = fsl_pkg::ST_SPIN; // R16
				fsl_pkg::ST_SPIN:
					if (spin_end)
						next_state = fsl_pkg::ST_RUN; // R12
				fsl_pkg::ST_RUN:
					if (!closed_loop_speed_control && i_direct_drive == 8'h00)
						next_state = fsl_pkg::ST_OFF; // R14
				default:
					next_state = state;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			state <= fsl_pkg::ST_OFF;
		else
			state <= next_state;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n || start_spin || !spinning)
			elapsed <= 32'h00000000;
		else
			elapsed <= elapsed + 32'h00000001;
	end

	// A good measurement anywhere in the attempt counts, not only the last.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n || start_spin || !spinning)
			tach_seen <= 1'b0;
		else if (i_tach_valid && !stall)
			tach_seen <= 1'b1; // R3
	end

	// Step limiting works in a signed 12-bit domain so neither direction wraps.
	always_comb
	begin
		diff = $signed({2'h0, i_drive_request}) - $signed({2'h0, o_drive});
		step_s = $signed({4'h0, drive_step_limit});
		if (!i_derivative_option[1] && diff > step_s)
			cand = {1'b0, o_drive} + {3'h0, drive_step_limit}; // R5 R7 R8
		else if (!i_derivative_option[1] && diff < -step_s)
			cand = {1'b0, o_drive} - {3'h0, drive_step_limit}; // R5
		else
			cand = {1'b0, i_drive_request}; // R6
		if (cand > {1'b0, full})
			cand = {1'b0, full};
		if (cand < {1'b0, min_ext})
			cand = {1'b0, min_ext}; // R9
		run_drive = cand[9:0];
	end

	always_comb
	begin
		next_drive = o_drive;
		case (next_state)
			fsl_pkg::ST_KICK:
				next_drive = full; // R16
			fsl_pkg::ST_SPIN:
				next_drive = spin_level; // R1
			fsl_pkg::ST_RUN:
				if (!closed_loop_speed_control)
					next_drive = direct_ext;
				else if (i_update_tick && !target_bad)
					next_drive = run_drive; // R5 R9
			fsl_pkg::ST_OFF:
				next_drive = fsl_pkg::DRIVE_OFF; // R17
			default:
				next_drive = fsl_pkg::DRIVE_OFF;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			o_drive <= fsl_pkg::DRIVE_OFF;
			o_spin_active <= 1'b0;
		end
		else
		begin
			o_drive <= next_drive;
			o_spin_active <= next_state == fsl_pkg::ST_KICK || next_state == fsl_pkg::ST_SPIN;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			spin_up_config <= fsl_pkg::RST_SPIN_CFG;
			drive_step_limit <= fsl_pkg::RST_STEP;
			minimum_drive <= fsl_pkg::RST_MIN_DRIVE;
			stall_count_threshold <= fsl_pkg::RST_THRESH;
			mask <= '0;
		end
		else if (bus_wr)
		begin
			case (bus_idx)
				fsl_pkg::IDX_SPIN_CFG:
					spin_up_config <= i_wb_dat[7:0];
				fsl_pkg::IDX_STEP:
					drive_step_limit <= i_wb_dat[7:0];
				fsl_pkg::IDX_MIN_DRIVE:
					minimum_drive <= i_wb_dat[7:0];
				fsl_pkg::IDX_THRESH:
					stall_count_threshold <= i_wb_dat[7:0];
				fsl_pkg::IDX_MASK:
					mask <= i_wb_dat[fsl_pkg::STAT_W-1:0];
				default:
					mask <= mask;
			endcase
		end
	end

	// A new event in the clearing cycle survives, so no failure is lost.
	always_comb
	begin
		stat_set = '0;
		stat_set[fsl_pkg::STAT_SPIN_FAIL] = spin_end && !spin_ok; // R3 R19
		stat_set[fsl_pkg::STAT_STALL] = closed_loop_speed_control && stall_restart;
		stat_clr = '0;
		if (bus_wr && bus_idx == fsl_pkg::IDX_STATUS)
			stat_clr = i_wb_dat[fsl_pkg::STAT_W-1:0];
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			status <= '0;
		else
			status <= (status & ~stat_clr) | stat_set; // R19
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else
			o_irq <= |(status & mask); // R3
	end

	// Single-wait-state slave: every access, mapped or not, is acknowledged.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end
		else
		begin
			o_wb_ack <= bus_req;
			o_wb_dat <= 32'h00000000;
			if (bus_req && !i_wb_we)
			begin
				case (bus_idx)
					fsl_pkg::IDX_SPIN_CFG:
						o_wb_dat <= {24'h000000, spin_up_config};
					fsl_pkg::IDX_STEP:
						o_wb_dat <= {24'h000000, drive_step_limit};
					fsl_pkg::IDX_MIN_DRIVE:
						o_wb_dat <= {24'h000000, minimum_drive};
					fsl_pkg::IDX_THRESH:
						o_wb_dat <= {24'h000000, stall_count_threshold};
					fsl_pkg::IDX_STATUS:
						o_wb_dat <= {30'h00000000, status};
					fsl_pkg::IDX_MASK:
						o_wb_dat <= {30'h00000000, mask};
					fsl_pkg::IDX_DRIVE:
						o_wb_dat <= {20'h00000, state, o_drive};
					default:
						o_wb_dat <= 32'h00000000;
				endcase
			end
		end
	end

	a_kick_full: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R16
		state == fsl_pkg::ST_KICK && $past(state) == fsl_pkg::ST_KICK |-> o_drive == full)
		else $error("kick phase drive is not full scale");

	a_spin_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R1
		state == fsl_pkg::ST_SPIN && $stable(spin_up_config) && $stable(i_pwm_base)
		|-> o_drive == spin_level)
		else $error("spin phase drive differs from spin level");

	a_step_clip: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R5
		state == fsl_pkg::ST_RUN && closed_loop_speed_control && i_update_tick && !i_derivative_option[1]
		&& !target_bad && !target_ff && !i_tach_valid && o_drive >= min_ext
		&& o_drive <= full
		|=> (o_drive >= $past(o_drive) ? o_drive - $past(o_drive)
		: $past(o_drive) - o_drive) <= {2'h0, $past(drive_step_limit)})
		else $error("drive change exceeds step limit");

	a_min_floor: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R9
		state == fsl_pkg::ST_RUN && closed_loop_speed_control && i_update_tick && !target_bad && !target_ff
		&& !i_tach_valid |=> o_drive >= $past(min_ext))
		else $error("closed loop drive below minimum");

	a_target_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R17
		closed_loop_speed_control && target_ff |=> o_drive == fsl_pkg::DRIVE_OFF && !o_spin_active)
		else $error("drive not off for target FFh");

	a_retry_now: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R4
		retry && !target_ff |=> o_spin_active && elapsed == 32'h00000000)
		else $error("failed spin-up not retried at once");

	a_stall_restart: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R13
		closed_loop_speed_control && !target_ff && stall_restart |=> o_spin_active && status[fsl_pkg::STAT_STALL])
		else $error("stall did not start spin-up");

	a_hold_target: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R15
		state == fsl_pkg::ST_RUN && closed_loop_speed_control && target_bad && !target_ff && !i_tach_valid
		|=> $stable(o_drive))
		else $error("drive moved for an ignored target");

	a_manual_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R14
		!closed_loop_speed_control && state == fsl_pkg::ST_OFF |=> o_spin_active == ($past(i_direct_drive) != 8'h00))
		else $error("manual spin-up start mismatch");

	a_fail_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R19
		status[fsl_pkg::STAT_SPIN_FAIL] && !stat_clr[fsl_pkg::STAT_SPIN_FAIL]
		|=> status[fsl_pkg::STAT_SPIN_FAIL])
		else $error("spin failure flag lost without a clear");

	a_end_check: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
		spin_end && !spin_ok |=> status[fsl_pkg::STAT_SPIN_FAIL] ##1
		(o_irq || !$past(mask[fsl_pkg::STAT_SPIN_FAIL])))
		else $error("failed spin-up not flagged");

endmodule

// >>> rtl/fsl_pkg.sv
// Constants shared by the fan spin-up and drive step limiter.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus.
package fsl_pkg;

	// Register word indices; the byte address is four times the index.
	localparam logic [5:0] IDX_SPIN_CFG = 6'h06;
	localparam logic [5:0] IDX_STEP = 6'h07;
	localparam logic [5:0] IDX_MIN_DRIVE = 6'h08;
	localparam logic [5:0] IDX_THRESH = 6'h09;
	localparam logic [5:0] IDX_STATUS = 6'h14;
	localparam logic [5:0] IDX_MASK = 6'h15;
	localparam logic [5:0] IDX_DRIVE = 6'h16;
	localparam int ADR_IDX_LSB = 2;
	localparam int ADR_IDX_MSB = 7;

	// Reset values.
	localparam logic [7:0] RST_SPIN_CFG = 8'h19;
	localparam logic [7:0] RST_STEP = 8'h10;
	localparam logic [7:0] RST_MIN_DRIVE = 8'h66;
	localparam logic [7:0] RST_THRESH = 8'hF5;

	// Spin-up configuration fields.
	localparam int SKIP_KICK_BIT = 5;
	localparam int SPIN_DRIVE_LEVEL_MSB = 4;
	localparam int SPIN_DRIVE_LEVEL_LSB = 2;
	localparam int SPIN_TIME_MSB = 1;
	localparam int SPIN_TIME_LSB = 0;

	// Status and mask bits.
	localparam int STAT_W = 2;
	localparam int STAT_SPIN_FAIL = 0;
	localparam int STAT_STALL = 1;

	// Shortest spin time and its cycle count at the system clock rate.
	localparam int SPIN_BASE_US = 250000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SPIN_BASE_CYCLES = SPIN_BASE_US / CLK_PERIOD_NS * 1000;

	// Spin level in percent: base plus step per code, over full scale.
	localparam logic [6:0] PCT_BASE = 7'h1E;
	localparam logic [6:0] PCT_STEP = 7'h05;
	localparam logic [16:0] PCT_FULL = 17'h00064;

	// Duty values and tach byte positions.
	localparam logic [9:0] FULL_10 = 10'h3FF;
	localparam logic [9:0] FULL_8 = 10'h0FF;
	localparam logic [9:0] DRIVE_OFF = 10'h000;
	localparam logic [7:0] TARGET_OFF = 8'hFF;
	localparam logic [1:0] BASE_8BIT = 2'h0;
	localparam int TACH_HI_MSB = 12;
	localparam int TACH_HI_LSB = 5;

	typedef enum logic [1:0] {ST_OFF, ST_KICK, ST_SPIN, ST_RUN} fsl_state_e;

endpackage

// >>> test/fsl_fan_model.sv
// Behavioural fan with tachometer output for the spin-up limiter bench.
// Assumes the design clock; the bench commands stalls through i_stall.
`timescale 1ns/1ps
module fsl_fan_model (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [9:0] i_drive,
	input wire logic i_stall,
	output logic [12:0] o_tach_reading,
	output logic o_tach_valid
);
	logic [2:0] phase;

	// A stopped or stalled fan shows the largest count, as a very long revolution would.
	// Pulses come every six cycles so that even the shortest spin attempt sees one.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n || i_drive == 10'h000)
		begin
			phase <= 3'h0;
			o_tach_valid <= 1'b0;
			o_tach_reading <= 13'h1FFF;
		end
		else
		begin
			phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
			o_tach_valid <= (phase == 3'h5);
			o_tach_reading <= i_stall ? 13'h1FFF : 13'h0400;
		end
	end
endmodule

// >>> test/fsl_spin_step_limiter_test.sv
// Self-checking bench for the spin-up sequencer and drive step limiter.
// Assumes the fan model file is compiled first; spin base shortened to 16 cycles.
`timescale 1ns/1ps
module fsl_spin_step_limiter_test;
	localparam int P_BASE = 16;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic ack;
	logic closed = 1'b0;
	logic [1:0] dopt = 2'h0;
	logic [1:0] base = 2'h0;
	logic tick = 1'b0;
	logic [9:0] req = 10'h000;
	logic [7:0] direct = 8'h00;
	logic [12:0] target = 13'h1FE0;
	logic stall = 1'b0;
	logic [12:0] reading;
	logic valid;
	logic [9:0] drive;
	logic spin;
	logic irq;
	int err_count = 0;
	int checks_done = 0;

	always #5 ref_clk = ~ref_clk;

	fsl_spin_step_limiter #(.P_SPIN_BASE_CYCLES(P_BASE)) u_fsl_spin_step_limiter (
		.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_closed_loop_speed_control(closed),
		.i_derivative_option(dopt), .i_pwm_base(base), .i_update_tick(tick),
		.i_drive_request(req), .i_direct_drive(direct), .i_tach_reading(reading),
		.i_tach_valid(valid), .i_tach_target(target), .o_drive(drive),
		.o_spin_active(spin), .o_irq(irq)
	);

	fsl_fan_model u_fsl_fan_model (
		.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_drive(drive), .i_stall(stall),
		.o_tach_reading(reading), .o_tach_valid(valid)
	);

	task automatic summarize();
		$display("checks_done=%0d err_count=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
		checks_done++;
		if (got !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", name, e, got);
		end
	endtask

	task automatic timeout(input string name);
		err_count++;
		$display("MISMATCH %s expected response seen timeout", name);
		summarize();
	endtask

	// The request stays up until ack is sampled high, then drops for a cycle.
	task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			timeout("bus ack");
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] e);
		logic [31:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk($sformatf("register %0h", idx), {24'h000000, e}, q);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, idx, d, q);
	endtask

	task automatic wait_spin(input logic v, output int n);
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (spin !== v && n < 400);
		if (n >= 400)
			timeout("spin active");
	endtask

	task automatic upd(input logic [1:0] o, input logic [9:0] r, input logic [9:0] e);
		@(posedge ref_clk);
		tick <= 1'b1;
		dopt <= o;
		req <= r;
		@(posedge ref_clk);
		tick <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("drive", {22'h000000, e}, {22'h000000, drive});
	endtask

	initial
	begin
		int n;
		logic [31:0] q;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(fsl_pkg::IDX_SPIN_CFG, 8'h19);
		rd(fsl_pkg::IDX_STEP, 8'h10);
		rd(fsl_pkg::IDX_MIN_DRIVE, 8'h66);
		rd(fsl_pkg::IDX_THRESH, 8'hF5);
		wr(6'h0F, 8'h55);
		rd(6'h0F, 8'h00);
		chk("idle spin", 32'h0, {31'h0, spin});
		direct <= 8'h40;
		wait_spin(1'b1, n);
		repeat (3) @(posedge ref_clk);
		chk("kick drive", 32'h0FF, {22'h000000, drive});
		repeat (8) @(posedge ref_clk);
		chk("spin level", 32'h099, {22'h000000, drive});
		wait_spin(1'b0, n);
		repeat (2) @(posedge ref_clk);
		chk("direct drive", 32'h040, {22'h000000, drive});
		direct <= 8'h00;
		closed <= 1'b1;
		base <= 2'h1;
		repeat (3) @(posedge ref_clk);
		chk("off drive", 32'h000, {22'h000000, drive});
		wr(fsl_pkg::IDX_MIN_DRIVE, 8'h60);
		rd(fsl_pkg::IDX_MIN_DRIVE, 8'h60);
		wr(fsl_pkg::IDX_SPIN_CFG, 8'h38);
		stall <= 1'b1;
		target <= 13'h1000;
		wait_spin(1'b1, n);
		repeat (2) @(posedge ref_clk);
		chk("no kick level", 32'h265, {22'h000000, drive});
		n = 0;
		repeat (40)
		begin
			@(posedge ref_clk);
			if (spin !== 1'b1)
				n++;
		end
		chk("retry gap", 32'h0, n);
		rd(fsl_pkg::IDX_STATUS, 8'h01);
		wr(fsl_pkg::IDX_MASK, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk("irq set", 32'h1, {31'h0, irq});
		stall <= 1'b0;
		wait_spin(1'b0, n);
		wr(fsl_pkg::IDX_STATUS, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk("irq clear", 32'h0, {31'h0, irq});
		rd(fsl_pkg::IDX_STATUS, 8'h00);
		upd(2'h0, 10'h3FF, 10'h275);
		upd(2'h1, 10'h000, 10'h265);
		upd(2'h2, 10'h3FF, 10'h3FF);
		upd(2'h3, 10'h000, 10'h180);
		target <= 13'h1F00;
		upd(2'h2, 10'h300, 10'h180);
		target <= 13'h1000;
		base <= 2'h0;
		upd(2'h2, 10'h3FF, 10'h0FF);
		upd(2'h0, 10'h000, 10'h0EF);
		wb(1'b0, fsl_pkg::IDX_DRIVE, 8'h00, q);
		chk("drive readback", 32'h00000CEF, q);
		wr(fsl_pkg::IDX_SPIN_CFG, 8'h3B);
		stall <= 1'b1;
		wait_spin(1'b1, n);
		stall <= 1'b0;
		wait_spin(1'b0, n);
		chk("spin time", 32'h1, {31'h0, (n >= 125 && n <= 129)});
		rd(fsl_pkg::IDX_STATUS, 8'h02);
		chk("masked irq", 32'h0, {31'h0, irq});
		target <= 13'h1FE0;
		repeat (3) @(posedge ref_clk);
		chk("off again", 32'h000, {22'h000000, drive});
		summarize();
	end
endmodule
